// [inc/power_seq_pkg.sv]
// Package with types, register layout and timing constants of the power-state sequencer
package power_seq_pkg;

	// Clock rate
	localparam int CLK_MHZ = 25;

	// Cycle counter
	localparam int CNT_W = 20;
	typedef logic [CNT_W-1:0] count_t;

	// Times in microseconds and their cycle counts
	localparam int BUCK_TIMEOUT_US   = 2000;
	localparam int LRAIL_TIMEOUT_US  = 1000;
	localparam int GAIN_READ_US      = 50;
	localparam int DELAY_UNIT_US     = 100;
	localparam int SS_UNIT_US        = 10;
	localparam int CP_SETTLE_US      = 100;
	localparam count_t BUCK_TIMEOUT_CYCLES  = count_t'(BUCK_TIMEOUT_US * CLK_MHZ);
	localparam count_t LRAIL_TIMEOUT_CYCLES = count_t'(LRAIL_TIMEOUT_US * CLK_MHZ);
	localparam count_t GAIN_READ_CYCLES     = count_t'(GAIN_READ_US * CLK_MHZ);
	localparam count_t DELAY_UNIT_CYCLES    = count_t'(DELAY_UNIT_US * CLK_MHZ);
	localparam count_t SS_UNIT_CYCLES       = count_t'(SS_UNIT_US * CLK_MHZ);
	localparam count_t CP_SETTLE_CYCLES     = count_t'(CP_SETTLE_US * CLK_MHZ);

	// Register byte offsets
	localparam logic [11:0] CONFIG_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;

	// Config register fields
	localparam int GAIN_FIELD_LSB    = 0;
	localparam int ANALOG_GAIN_BIT   = 4;
	localparam int TURNON_DELAY_LSB  = 8;
	localparam int SOFTSTART_LSB     = 12;
	localparam logic [3:0] GAIN_FIELD_RESET   = 4'h0;
	localparam logic       ANALOG_GAIN_RESET  = 1'b0;
	localparam logic [3:0] TURNON_DELAY_RESET = 4'h4;
	localparam logic [3:0] SOFTSTART_RESET    = 4'h3;

	// Status register fields
	localparam int STATE_LSB        = 0;
	localparam int GAIN_VALUE_LSB   = 4;
	localparam int BUCK_FAULT_BIT   = 8;
	localparam int LRAIL_FAULT_BIT  = 9;
	localparam int CONFIG_FAULT_BIT = 10;
	localparam int LRAIL_FAIL_BIT   = 11;

	localparam logic [3:0] RAMP_FULL = 4'hF;

	typedef enum logic [3:0] {
		off_state              = 4'h0,
		config_read_state      = 4'h1,
		buck_start_state       = 4'h2,
		gain_read_state        = 4'h3,
		turnon_delay_state     = 4'h4,
		logic_rail_start_state = 4'h5,
		wait_enable_state      = 4'h6,
		charge_pump_state      = 4'h7,
		active_state           = 4'h8,
		stop_state             = 4'h9,
		logic_rail_fail_state  = 4'hA
	} power_state_t;

	// Indications from pins and analog monitors, all asynchronous to pclk
	typedef struct packed {
		logic       supply_enable_pin;
		logic       driver_enable_pin;
		logic       battery_supply_ok;
		logic       config_mem_done;
		logic       config_mem_fault;
		logic       step_down_rail_good;
		logic       logic_supply_rail_good;
		logic       low_pump_good;
		logic       high_pump_good;
		logic [3:0] gain_pin_code;
	} sense_in_t;

	// Enables toward the power blocks
	typedef struct packed {
		logic       config_read_req;
		logic       buck_enable;
		logic       gain_sense_enable;
		logic       logic_rail_enable;
		logic [3:0] logic_rail_ramp;
		logic       adc_enable;
		logic       low_pump_enable;
		logic       high_pump_enable;
		logic       pwm_path_enable;
		logic [3:0] amp_gain;
	} power_ctrl_t;

endpackage : power_seq_pkg

// [rtl/sense_sync.sv]
// Two-stage synchroniser for the asynchronous sense inputs
`timescale 1ns/1ns
module sense_sync (
	input  wire logic                    pclk,     // Clock
	input  wire logic                    presetn,  // Asynchronous reset, active low
	input  wire power_seq_pkg::sense_in_t async_in, // Raw inputs
	output      power_seq_pkg::sense_in_t sync_out  // Synchronised inputs
);

	typedef struct packed {
		power_seq_pkg::sense_in_t meta;
		power_seq_pkg::sense_in_t stable;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	localparam int W = $bits(power_seq_pkg::sense_in_t);

	// First stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				next_s.meta[i]   = async_in[i];
				next_s.stable[i] = s.meta[i];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stable;

endmodule : sense_sync

// [rtl/gate_driver_power_state_fsm.sv]
// Power-state sequencer of the gate driver with its APB register slave
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Function
// - Buck starts only once battery lockout cleared and supply enable high, any order.
// - Reset holds the machine in the off state.
// - Configuration memory is read before any further block is enabled.
// - A configuration memory fault sends the machine to stop.
// - Buck enabled in buck start; rail timeout shuts buck and enters stop.
// - Gain pin sensed only with analog select; otherwise gain from register.
// - Logic rail ramps with delay and soft start, then waits for driver enable.
// - Stop after start-up fault persists until reset or driver enable toggle.
// - Register interface is refused while stopped.
// - Charge pumps enabled; move to active when both reach target.
// - Active state opens the PWM path.
// - Driver enable low in active: pumps off, PWM off, back to standby.
// - Logic rail failure after power-up enters fail state until supply enable toggle.
// - In the logic rail fail state buck and ADC keep running.
// - Soft-start time is writable over the register interface.
// - Turn-on delay is inserted after the gain period before the ramp.
// - High pump starts after low pump is good; PWM needs both good.
module gate_driver_power_state_fsm #(
	parameter power_seq_pkg::count_t BUCK_TIMEOUT  = power_seq_pkg::BUCK_TIMEOUT_CYCLES,  // Buck rail wait
	parameter power_seq_pkg::count_t LRAIL_TIMEOUT = power_seq_pkg::LRAIL_TIMEOUT_CYCLES  // Logic rail wait
) (
	input  wire logic                      pclk,     // Clock, 25 MHz
	input  wire logic                      presetn,  // Asynchronous reset, active low
	input  wire logic                      psel,     // APB select
	input  wire logic                      penable,  // APB enable
	input  wire logic                      pwrite,   // APB direction
	input  wire logic [11:0]               paddr,    // APB byte address
	input  wire logic [31:0]               pwdata,   // APB write data
	output      logic [31:0]               prdata,   // APB read data
	output      logic                      pready,   // APB ready
	output      logic                      pslverr,  // APB error
	input  wire power_seq_pkg::sense_in_t  sense,    // Pin and monitor inputs
	output      power_seq_pkg::power_ctrl_t ctrl     // Power block enables
);

	typedef struct packed {
		power_seq_pkg::power_state_t st;
		power_seq_pkg::count_t       cnt;
		logic [3:0]                  units;
		logic                        seen_low;
		logic [3:0]                  gain_field;
		logic                        analog_gain_select;
		logic [3:0]                  logic_rail_turnon_delay;
		logic [3:0]                  logic_rail_softstart_time;
		logic                        buck_fault;
		logic                        lrail_fault;
		logic                        config_fault;
		logic                        lrail_fail;
		logic [31:0]                 prdata;
		logic                        pready;
		logic                        pslverr;
		power_seq_pkg::power_ctrl_t  ctrl;
	} fsm_state_t;

	fsm_state_t                s;
	fsm_state_t                next_s;
	power_seq_pkg::sense_in_t  in;

	// Every sense input is a pin or an analog monitor output
	sense_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (sense),
		.sync_out (in)
	);

	logic stopped;
	logic access;
	logic hit_config;
	logic hit_status;
	logic [31:0] status_word;
	logic [31:0] config_word;

	always_comb begin
		stopped = (s.st == power_seq_pkg::stop_state);
		access = psel && penable;
		hit_config = (paddr[11:2] == power_seq_pkg::CONFIG_OFFSET[11:2]);
		hit_status = (paddr[11:2] == power_seq_pkg::STATUS_OFFSET[11:2]);
		config_word = '0;
		config_word[power_seq_pkg::GAIN_FIELD_LSB +: 4] = s.gain_field;
		config_word[power_seq_pkg::ANALOG_GAIN_BIT] = s.analog_gain_select;
		config_word[power_seq_pkg::TURNON_DELAY_LSB +: 4] = s.logic_rail_turnon_delay;
		config_word[power_seq_pkg::SOFTSTART_LSB +: 4] = s.logic_rail_softstart_time;
		status_word = '0;
		status_word[power_seq_pkg::STATE_LSB +: 4] = s.st;
		status_word[power_seq_pkg::GAIN_VALUE_LSB +: 4] = s.ctrl.amp_gain;
		status_word[power_seq_pkg::BUCK_FAULT_BIT] = s.buck_fault;
		status_word[power_seq_pkg::LRAIL_FAULT_BIT] = s.lrail_fault;
		status_word[power_seq_pkg::CONFIG_FAULT_BIT] = s.config_fault;
		status_word[power_seq_pkg::LRAIL_FAIL_BIT] = s.lrail_fail;
	end

	always_comb begin
		next_s = s;
		next_s.cnt = s.cnt + power_seq_pkg::count_t'(1);

		// APB slave: one wait state, write commits on the ready edge
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (access && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			if (stopped) begin
				next_s.pslverr = 1'b1;
			end else if (hit_config) begin
				next_s.prdata = pwrite ? '0 : config_word;
			end else if (hit_status && !pwrite) begin
				next_s.prdata = status_word;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (access && s.pready && pwrite && !s.pslverr && hit_config) begin
			next_s.gain_field = pwdata[power_seq_pkg::GAIN_FIELD_LSB +: 4];
			next_s.analog_gain_select = pwdata[power_seq_pkg::ANALOG_GAIN_BIT];
			next_s.logic_rail_turnon_delay = pwdata[power_seq_pkg::TURNON_DELAY_LSB +: 4];
			next_s.logic_rail_softstart_time = pwdata[power_seq_pkg::SOFTSTART_LSB +: 4];
		end

		unique case (s.st)
			power_seq_pkg::off_state: begin
				next_s.ctrl = '0;
				next_s.cnt = '0;
				// Either condition may come first; both must hold together
				if (in.battery_supply_ok && in.supply_enable_pin) begin
					next_s.st = power_seq_pkg::config_read_state;
					next_s.ctrl.config_read_req = 1'b1;
					next_s.buck_fault = 1'b0;
					next_s.lrail_fault = 1'b0;
					next_s.config_fault = 1'b0;
					next_s.lrail_fail = 1'b0;
				end
			end

			power_seq_pkg::config_read_state: begin
				next_s.cnt = '0;
				if (in.config_mem_fault) begin
					next_s.st = power_seq_pkg::stop_state;
					next_s.ctrl.config_read_req = 1'b0;
					next_s.config_fault = 1'b1;
					next_s.seen_low = 1'b0;
				end else if (in.config_mem_done) begin
					next_s.st = power_seq_pkg::buck_start_state;
					next_s.ctrl.config_read_req = 1'b0;
					next_s.ctrl.buck_enable = 1'b1;
				end
			end

			power_seq_pkg::buck_start_state: begin
				if (in.step_down_rail_good) begin
					next_s.cnt = '0;
					next_s.units = '0;
					if (s.analog_gain_select) begin
						next_s.st = power_seq_pkg::gain_read_state;
						next_s.ctrl.gain_sense_enable = 1'b1;
					end else begin
						next_s.st = power_seq_pkg::turnon_delay_state;
						next_s.ctrl.amp_gain = s.gain_field;
					end
				end else if (s.cnt >= BUCK_TIMEOUT - power_seq_pkg::count_t'(1)) begin
					next_s.st = power_seq_pkg::stop_state;
					next_s.ctrl.buck_enable = 1'b0;
					next_s.buck_fault = 1'b1;
					next_s.seen_low = 1'b0;
				end
			end

			power_seq_pkg::gain_read_state: begin
				if (s.cnt >= power_seq_pkg::GAIN_READ_CYCLES - power_seq_pkg::count_t'(1)) begin
					next_s.st = power_seq_pkg::turnon_delay_state;
					next_s.ctrl.gain_sense_enable = 1'b0;
					next_s.ctrl.amp_gain = in.gain_pin_code;
					next_s.cnt = '0;
					next_s.units = '0;
				end
			end

			power_seq_pkg::turnon_delay_state: begin
				// Delay in units; zero means ramp at once
				if (s.units == s.logic_rail_turnon_delay) begin
					next_s.st = power_seq_pkg::logic_rail_start_state;
					next_s.ctrl.logic_rail_enable = 1'b1;
					next_s.ctrl.logic_rail_ramp = '0;
					next_s.cnt = '0;
					next_s.units = '0;
				end else if (s.cnt >= power_seq_pkg::DELAY_UNIT_CYCLES - power_seq_pkg::count_t'(1)) begin
					next_s.cnt = '0;
					next_s.units = s.units + 4'h1;
				end
			end

			power_seq_pkg::logic_rail_start_state: begin
				if (s.ctrl.logic_rail_ramp != power_seq_pkg::RAMP_FULL) begin
					// Each ramp step lasts softstart_time plus one units
					if (s.cnt >= power_seq_pkg::SS_UNIT_CYCLES - power_seq_pkg::count_t'(1)) begin
						next_s.cnt = '0;
						if (s.units == s.logic_rail_softstart_time) begin
							next_s.units = '0;
							next_s.ctrl.logic_rail_ramp = s.ctrl.logic_rail_ramp + 4'h1;
						end else begin
							next_s.units = s.units + 4'h1;
						end
					end
				end else if (in.logic_supply_rail_good) begin
					next_s.st = power_seq_pkg::wait_enable_state;
					next_s.ctrl.adc_enable = 1'b1;
				end else if (s.cnt >= LRAIL_TIMEOUT - power_seq_pkg::count_t'(1)) begin
					next_s.st = power_seq_pkg::stop_state;
					next_s.ctrl = '0;
					next_s.lrail_fault = 1'b1;
					next_s.seen_low = 1'b0;
				end
			end

			power_seq_pkg::wait_enable_state: begin
				next_s.cnt = '0;
				if (!in.logic_supply_rail_good) begin
					next_s.st = power_seq_pkg::logic_rail_fail_state;
					next_s.ctrl.logic_rail_enable = 1'b0;
					next_s.lrail_fail = 1'b1;
					next_s.seen_low = 1'b0;
				end else if (in.driver_enable_pin) begin
					next_s.st = power_seq_pkg::charge_pump_state;
					next_s.ctrl.low_pump_enable = 1'b1;
				end
			end

			power_seq_pkg::charge_pump_state: begin
				if (!in.low_pump_good) begin
					next_s.cnt = '0;
				end else if (s.cnt >= power_seq_pkg::CP_SETTLE_CYCLES - power_seq_pkg::count_t'(1)) begin
					next_s.ctrl.high_pump_enable = 1'b1;
				end
				if (!in.logic_supply_rail_good) begin
					next_s.st = power_seq_pkg::logic_rail_fail_state;
					next_s.ctrl.logic_rail_enable = 1'b0;
					next_s.ctrl.low_pump_enable = 1'b0;
					next_s.ctrl.high_pump_enable = 1'b0;
					next_s.lrail_fail = 1'b1;
					next_s.seen_low = 1'b0;
				end else if (!in.driver_enable_pin) begin
					next_s.st = power_seq_pkg::wait_enable_state;
					next_s.ctrl.low_pump_enable = 1'b0;
					next_s.ctrl.high_pump_enable = 1'b0;
				end else if (s.ctrl.high_pump_enable && in.low_pump_good && in.high_pump_good) begin
					next_s.st = power_seq_pkg::active_state;
					next_s.ctrl.pwm_path_enable = 1'b1;
				end
			end

			power_seq_pkg::active_state: begin
				next_s.cnt = '0;
				if (!in.logic_supply_rail_good) begin
					next_s.st = power_seq_pkg::logic_rail_fail_state;
					next_s.ctrl.logic_rail_enable = 1'b0;
					next_s.ctrl.low_pump_enable = 1'b0;
					next_s.ctrl.high_pump_enable = 1'b0;
					next_s.ctrl.pwm_path_enable = 1'b0;
					next_s.lrail_fail = 1'b1;
					next_s.seen_low = 1'b0;
				end else if (!in.driver_enable_pin) begin
					next_s.st = power_seq_pkg::wait_enable_state;
					next_s.ctrl.low_pump_enable = 1'b0;
					next_s.ctrl.high_pump_enable = 1'b0;
					next_s.ctrl.pwm_path_enable = 1'b0;
				end
			end

			power_seq_pkg::stop_state: begin
				// Restart needs a low then a high on driver enable
				next_s.ctrl = '0;
				next_s.cnt = '0;
				if (!in.driver_enable_pin) begin
					next_s.seen_low = 1'b1;
				end else if (s.seen_low) begin
					next_s.st = power_seq_pkg::off_state;
					next_s.seen_low = 1'b0;
				end
			end

			power_seq_pkg::logic_rail_fail_state: begin
				// Buck and ADC stay up so the fault can still be observed
				next_s.ctrl.buck_enable = 1'b1;
				next_s.ctrl.adc_enable = 1'b1;
				next_s.ctrl.logic_rail_enable = 1'b0;
				next_s.ctrl.pwm_path_enable = 1'b0;
				next_s.cnt = '0;
				if (!in.supply_enable_pin) begin
					next_s.seen_low = 1'b1;
				end else if (s.seen_low) begin
					next_s.st = power_seq_pkg::off_state;
					next_s.seen_low = 1'b0;
				end
			end

			default: begin
				next_s.st = power_seq_pkg::off_state;
				next_s.ctrl = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= power_seq_pkg::off_state;
			s.gain_field <= power_seq_pkg::GAIN_FIELD_RESET;
			s.analog_gain_select <= power_seq_pkg::ANALOG_GAIN_RESET;
			s.logic_rail_turnon_delay <= power_seq_pkg::TURNON_DELAY_RESET;
			s.logic_rail_softstart_time <= power_seq_pkg::SOFTSTART_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign ctrl = s.ctrl;

endmodule : gate_driver_power_state_fsm

// [sim/power_seq_monitor.sv]
// Concurrent checks on the power-state sequencer ports
`timescale 1ns/1ns
module power_seq_monitor #(
	parameter power_seq_pkg::count_t BUCK_TIMEOUT  = 20'h00014, // Buck rail wait
	parameter power_seq_pkg::count_t LRAIL_TIMEOUT = 20'h00014  // Logic rail wait
) (
	input wire logic                       pclk,    // Clock
	input wire logic                       presetn, // Reset, active low
	input wire logic                       psel,    // Select
	input wire logic                       penable, // Enable
	input wire logic                       pwrite,  // Direction
	input wire logic [11:0]                paddr,   // Address
	input wire logic [31:0]                pwdata,  // Write data
	input wire logic [31:0]                prdata,  // Read data
	input wire logic                       pready,  // Ready
	input wire logic                       pslverr, // Error
	input wire power_seq_pkg::sense_in_t   sense,   // Sense pins
	input wire power_seq_pkg::power_ctrl_t ctrl     // Enables
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	power_seq_pkg::count_t bwait;
	power_seq_pkg::count_t lgood;
	logic                  buck_alone;
	assign buck_alone = ctrl.buck_enable && !ctrl.logic_rail_enable && !sense.step_down_rail_good;
	// Raw pins lead the synchroniser, so lgood can only run high and bwait only low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bwait <= '0;
			lgood <= '0;
		end else begin
			bwait <= buck_alone ? bwait + 1'b1 : '0;
			lgood <= (ctrl.low_pump_enable && sense.low_pump_good) ? lgood + 1'b1 : '0;
		end
	end
	chk_reset_quiet: assert property ($rose(presetn) |-> ctrl == '0)
		else $error("Enables not clear after reset");
	chk_buck_cause: assert property ($rose(ctrl.config_read_req) |->
		$past(sense.battery_supply_ok, 2) && $past(sense.supply_enable_pin, 2)) else $error("Start without supplies");
	chk_config_first: assert property (ctrl.config_read_req |->
		!(ctrl.buck_enable || ctrl.logic_rail_enable || ctrl.low_pump_enable)) else $error("Block on before config");
	chk_buck_timeout: assert property (bwait <= BUCK_TIMEOUT + 4)
		else $error("Buck kept on past its timeout");
	chk_pump_order: assert property ($rose(ctrl.high_pump_enable) |->
		lgood >= power_seq_pkg::CP_SETTLE_CYCLES) else $error("High pump before low pump settled");
	chk_pwm_pumps: assert property (ctrl.pwm_path_enable |-> ctrl.low_pump_enable && ctrl.high_pump_enable)
		else $error("PWM open without pumps");
	chk_drv_drop: assert property ($fell(sense.driver_enable_pin) && ctrl.pwm_path_enable |->
		##[1:5] !(ctrl.pwm_path_enable || ctrl.low_pump_enable || ctrl.high_pump_enable)) else $error("Drive not dropped");
	chk_rail_fail: assert property ($fell(sense.logic_supply_rail_good) && ctrl.adc_enable |->
		##[1:5] (ctrl.buck_enable && ctrl.adc_enable && !ctrl.logic_rail_enable)) else $error("Rail fail handling wrong");
	chk_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("Register answer not after one wait");
	cover property ($rose(ctrl.pwm_path_enable));
	cover property ($rose(ctrl.gain_sense_enable));
	cover property (pready && pslverr);
endmodule : power_seq_monitor

bind gate_driver_power_state_fsm power_seq_monitor #(.BUCK_TIMEOUT(BUCK_TIMEOUT), .LRAIL_TIMEOUT(LRAIL_TIMEOUT)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .ctrl(ctrl));

// [sim/mcu_model.sv]
// Behavioural companion controller that drives the driver-enable pin
`timescale 1ns/1ns
module mcu_model #(
	parameter int DLY = 5 // Cycles counted after the request; pin rises one cycle after the count ends
) (
	input  wire logic pclk,             // Clock
	input  wire logic presetn,          // Reset, active low
	input  wire logic cmd,              // Request from the bench
	input  wire logic rail_ok,          // Controller is powered
	output logic      driver_enable_pin // Driver-enable pin
);
	int cnt;
	// Firmware raises the pin only once powered, and only after its own boot delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt               <= 0;
			driver_enable_pin <= 1'b0;
		end else if (!cmd || !rail_ok) begin
			cnt               <= 0;
			driver_enable_pin <= 1'b0;
		end else if (cnt < DLY) begin
			cnt <= cnt + 1;
		end else begin
			driver_enable_pin <= 1'b1;
		end
	end
endmodule : mcu_model

// [sim/gate_driver_power_state_fsm_tb_top.sv]
// Self-checking bench of the power-state sequencer
`timescale 1ns/1ns
module gate_driver_power_state_fsm_tb_top;
	localparam logic [15:0] RQ = 16'h8000, BK = 16'h4000, GS = 16'h2000, LR = 16'h1000;
	localparam logic [15:0] AD = 16'h0080, LO = 16'h0040, HI = 16'h0020, PW = 16'h0010;
	localparam logic [11:0] CF = power_seq_pkg::CONFIG_OFFSET;
	localparam logic [11:0] ST = power_seq_pkg::STATUS_OFFSET;
	logic                       pclk    = 1'b0;
	logic                       presetn = 1'b0;
	logic                       psel    = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite  = 1'b0;
	logic [11:0]                paddr   = 12'h000;
	logic [31:0]                pwdata  = 32'h0;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	power_seq_pkg::sense_in_t   pins = '0;
	power_seq_pkg::sense_in_t   sense;
	power_seq_pkg::power_ctrl_t ctrl;
	logic [15:0]                cv;
	logic                       drv;
	logic                       mcu_cmd = 1'b0;
	logic                       mcu_alt = 1'b0;
	logic                       gs_seen = 1'b0;
	int                         error_cnt = 0;
	int                         check_count = 0;

	always #20 pclk = ~pclk;
	assign cv = ctrl;
	always_comb begin
		sense = pins;
		sense.driver_enable_pin = drv;
	end
	always @(posedge pclk) begin
		if (cv[13] === 1'b1) gs_seen <= 1'b1;
	end

	gate_driver_power_state_fsm #(.BUCK_TIMEOUT(20'h00014), .LRAIL_TIMEOUT(20'h00014)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense), .ctrl(ctrl));
	mcu_model #(.DLY(5)) u_mcu (.pclk(pclk), .presetn(presetn), .cmd(mcu_cmd),
		.rail_ok(ctrl.adc_enable | mcu_alt), .driver_enable_pin(drv));

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic chk_cv(input logic [15:0] m, input logic [15:0] exp);
		check("ctrl", {16'h0, cv & m}, {16'h0, exp});
	endtask : chk_cv

	// Bounded wait for the OR of the bits under the mask to reach the given level
	task automatic wait_on(input logic [15:0] m, input logic v, input int lim);
		int n;
		n = 0;
		while ((|(cv & m)) !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		check("wait", {m, 15'h0, (|(cv & m))}, {m, 15'h0, v});
		if (n >= lim) close_out();
	endtask : wait_on

	// One transfer: setup, access until ready, release, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] exp, input logic err);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (!w) check("rdata", prdata & m, exp);
		check("pslverr", {31'h0, pslverr}, {31'h0, err});
		// A transfer that never got its answer counts as a mismatch
		check("pready", {31'h0, pready}, 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) close_out();
		@(posedge pclk);
	endtask : apb

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ST, 32'h0, 32'h0000_0F0F, 32'h0, 1'b0);
		chk_cv(16'hFFFF, 16'h0000);
		apb(1'b0, CF, 32'h0, 32'h0000_FF1F, 32'h0000_3400, 1'b0);
		apb(1'b1, CF, 32'h0000_0005, 32'h0, 32'h0, 1'b0);
		apb(1'b0, CF, 32'h0, 32'h0000_FF1F, 32'h0000_0005, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 32'h0, 1'b1);
		apb(1'b1, ST, 32'h0000_0001, 32'h0, 32'h0, 1'b1);
		$display("Test registers done");
		pins.battery_supply_ok <= 1'b1;
		repeat (8) @(posedge pclk);
		chk_cv(RQ | BK, 16'h0000);
		pins.supply_enable_pin <= 1'b1;
		wait_on(RQ, 1'b1, 10);
		repeat (4) @(posedge pclk);
		chk_cv(BK | LR, 16'h0000);
		pins.config_mem_done <= 1'b1;
		wait_on(BK, 1'b1, 10);
		pins.step_down_rail_good <= 1'b1;
		wait_on(LR, 1'b1, 100);
		chk_cv(16'h000F, 16'h0005);
		check("gain sensed", {31'h0, gs_seen}, 32'h0);
		pins.logic_supply_rail_good <= 1'b1;
		wait_on(AD, 1'b1, 5000);
		chk_cv(16'h0F00, 16'h0F00);
		apb(1'b0, ST, 32'h0, 32'hF, 32'h6, 1'b0);
		mcu_cmd <= 1'b1;
		wait_on(LO, 1'b1, 50);
		pins.low_pump_good <= 1'b1;
		wait_on(HI, 1'b1, 3000);
		chk_cv(PW, 16'h0000);
		pins.high_pump_good <= 1'b1;
		wait_on(PW, 1'b1, 10);
		apb(1'b0, ST, 32'h0, 32'hF, 32'h8, 1'b0);
		mcu_cmd <= 1'b0;
		wait_on(PW, 1'b0, 20);
		chk_cv(LO | HI, 16'h0000);
		apb(1'b0, ST, 32'h0, 32'hF, 32'h6, 1'b0);
		pins.logic_supply_rail_good <= 1'b0;
		wait_on(LR, 1'b0, 10);
		chk_cv(BK | AD, BK | AD);
		apb(1'b0, ST, 32'h0, 32'h0000_0FFF, 32'h0000_085A, 1'b0);
		$display("Test start-up done");
		pins.supply_enable_pin <= 1'b0;
		pins.gain_pin_code     <= 4'h9;
		apb(1'b1, CF, 32'h0000_0113, 32'h0, 32'h0, 1'b0);
		apb(1'b0, ST, 32'h0, 32'hF, 32'hA, 1'b0);
		pins.supply_enable_pin <= 1'b1;
		wait_on(GS, 1'b1, 20);
		wait_on(GS, 1'b0, 1400);
		chk_cv(16'h000F, 16'h0009);
		repeat (2400) @(posedge pclk);
		chk_cv(LR, 16'h0000);
		wait_on(LR, 1'b1, 200);
		wait_on(LR, 1'b0, 4000);
		apb(1'b0, ST, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		apb(1'b1, CF, 32'h0, 32'h0, 32'h0, 1'b1);
		pins.step_down_rail_good <= 1'b0;
		repeat (20) @(posedge pclk);
		chk_cv(16'hFFFF, 16'h0000);
		$display("Test rail stop done");
		mcu_alt <= 1'b1;
		mcu_cmd <= 1'b1;
		wait_on(BK, 1'b1, 40);
		wait_on(BK, 1'b0, 40);
		apb(1'b0, ST, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		pins.config_mem_fault <= 1'b1;
		mcu_cmd <= 1'b0;
		repeat (10) @(posedge pclk);
		mcu_cmd <= 1'b1;
		wait_on(RQ, 1'b1, 40);
		wait_on(RQ, 1'b0, 10);
		chk_cv(BK, 16'h0000);
		apb(1'b0, ST, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		$display("Test faults done");
		pins.supply_enable_pin <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ST, 32'h0, 32'hF, 32'h0, 1'b0);
		$display("Test second reset done");
		close_out();
	end
endmodule : gate_driver_power_state_fsm_tb_top
